/* File: rtl/irq_logic_pkg.sv */
// Constants and carrier types for the converter interrupt logic
package irq_logic_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_IRQ_CONFIG = 8'h32;
    localparam logic [7:0] ADDR_IRQ_SOURCE_MASKS = 8'h33;
    localparam logic [7:0] ADDR_IRQ_LATCHED_FLAGS = 8'h36;

    // Reset values
    localparam logic [7:0] IRQ_CONFIG_RST = 8'h00;
    localparam logic [7:0] IRQ_SOURCE_MASKS_RST = 8'hFF;
    localparam logic [1:0] IRQ_LATCHED_RST = 2'h0;

    // Writable bits of the configuration register (7, 6-5, 2)
    localparam logic [7:0] IRQ_CONFIG_WR_MASK = 8'hE4;

    // Field positions: source bits in the mask and latch registers
    localparam int SRC_CLK_ERR_BIT = 7;
    localparam int SRC_PLL_LOCK_BIT = 6;
    localparam int SRC_LOW_BIT = 6;
    localparam int NUM_SOURCES = 2;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int IRQ_PULSE_US = 2000;
    localparam int IRQ_PERIOD_US = 4000;
    localparam int IRQ_PULSE_CYC = IRQ_PULSE_US * 1000 / CLK_PERIOD_NS;
    localparam int IRQ_PERIOD_CYC = IRQ_PERIOD_US * 1000 / CLK_PERIOD_NS;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        STYLE_LEVEL = 2'b00,
        STYLE_RESERVED = 2'b01,
        STYLE_PERIODIC = 2'b10,
        STYLE_ONESHOT = 2'b11
    } irq_style_t;

    // Configuration register layout, bit 7 first
    typedef struct packed {
        logic irq_polarity;
        irq_style_t style;
        logic [1:0] rsv_hi;
        logic readback_filter_select;
        logic [1:0] rsv_lo;
    } irq_cfg_t;

    // Register access request, one-cycle strobes
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Event pulses, one cycle each
    typedef struct packed {
        logic serial_audio_port_clk_err;
        logic pll_lock;
    } irq_evt_t;

endpackage

/* File: rtl/irq_logic.sv */
// Interrupt latch, mask and pin driver of the audio converter
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Pin is active low when polarity bit is 0, active high when 1.
// - Style 0 holds the pin active while any unmasked latch is pending.
// - Style 2 pulses the pin 2 ms in each 4 ms while pending.
// - Style 3 gives a 2 ms pulse after an unmasked event; a new one mid-pulse restarts it.
// - Filter bit 0 shows all latched events, 1 shows only unmasked ones.
// - Mask bit 7 gates the serial audio port clock error event.
// - Mask bit 6 gates the phase-locked loop lock event.
// - Mask register resets to all ones; low six bits stay writable.
// - Latch bit 7 reports a clock error and clears when read while visible in the readback.
// - Latch bit 6 reports a lock event; low six bits read zero.
// - Configuration register resets to zero.
module irq_logic
    import irq_logic_pkg::*;
#(
    parameter int PULSE_CYC = IRQ_PULSE_CYC,
    parameter int PERIOD_CYC = IRQ_PERIOD_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire reg_req_t req_in,
    input wire irq_evt_t evt_in,
    output logic [7:0] rdata_out,
    output logic irq_pin_out
);

    // ****************************************
    // Local widths and counts
    // ****************************************
    localparam int CNT_W = $clog2(PERIOD_CYC + 1);
    localparam logic [CNT_W-1:0] PULSE_N = CNT_W'(PULSE_CYC);
    localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYC - 1);
    localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    // ****************************************
    // Registers and next values
    // ****************************************
    irq_cfg_t cfg_r;
    irq_cfg_t cfg_nxt;
    logic [7:0] mask_r;
    logic [7:0] mask_nxt;
    logic [NUM_SOURCES-1:0] latch_r;
    logic [NUM_SOURCES-1:0] latch_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic shot_r;
    logic shot_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic pin_r;
    logic pin_nxt;

    // ****************************************
    // Decode
    // ****************************************
    wire logic [NUM_SOURCES-1:0] evt_w = evt_in;
    wire logic [NUM_SOURCES-1:0] mask_src =
        mask_r[SRC_CLK_ERR_BIT:SRC_LOW_BIT];
    wire logic wr_cfg = req_in.wr && (req_in.addr == ADDR_IRQ_CONFIG);
    wire logic wr_mask = req_in.wr && (req_in.addr == ADDR_IRQ_SOURCE_MASKS);
    wire logic rd_cfg = req_in.addr == ADDR_IRQ_CONFIG;
    wire logic rd_mask = req_in.addr == ADDR_IRQ_SOURCE_MASKS;
    wire logic rd_latch = req_in.addr == ADDR_IRQ_LATCHED_FLAGS;
    wire logic rd_latch_stb = req_in.rd && rd_latch;

    // Readback view of the latches, filtered by the mask if asked
    wire logic [NUM_SOURCES-1:0] latch_vis =
        cfg_r.readback_filter_select ? (latch_r & ~mask_src) : latch_r;

    // Pending and fresh unmasked events
    wire logic pending = |(latch_r & ~mask_src);
    wire logic new_evt = |(evt_w & ~mask_src);

    // ****************************************
    // Register writes
    // ****************************************
    // Reserved config bits are forced low so they always read zero
    assign cfg_nxt = wr_cfg
        ? irq_cfg_t'(req_in.wdata & IRQ_CONFIG_WR_MASK) : cfg_r;
    // All eight mask bits are writable, reserved ones included
    assign mask_nxt = wr_mask ? req_in.wdata : mask_r;

    // ****************************************
    // Event latches
    // ****************************************
    // Set wins over the read-clear, so an event during the read survives
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SOURCES; gi++) begin : g_latch
            assign latch_nxt[gi] = evt_w[gi] ||
                (latch_r[gi] && !(rd_latch_stb && latch_vis[gi]));
        end
    endgenerate

    // ****************************************
    // Read data
    // ****************************************
    // Unmapped addresses read zero; reserved latch bits read zero
    assign rdata_nxt = !req_in.rd ? rdata_r
        : rd_cfg ? 8'(cfg_r)
        : rd_mask ? mask_r
        : rd_latch ? {latch_vis, 6'h00}
        : 8'h00;

    // ****************************************
    // Pulse timer
    // ****************************************
    // One counter serves both timed styles; it idles at zero otherwise
    always_comb begin
        cnt_nxt = '0;
        shot_nxt = 1'b0;
        case (cfg_r.style)
            STYLE_PERIODIC: begin
                if (pending && cnt_r != PERIOD_LAST) begin
                    cnt_nxt = cnt_r + CNT_ONE;
                end
            end
            STYLE_ONESHOT: begin
                // A new event restarts the pulse rather than stacking
                if (new_evt) begin
                    shot_nxt = 1'b1;
                end else if (shot_r && cnt_r != PULSE_LAST) begin
                    shot_nxt = 1'b1;
                    cnt_nxt = cnt_r + CNT_ONE;
                end
            end
            default: begin
                cnt_nxt = '0;
            end
        endcase
    end

    // ****************************************
    // Pin driver
    // ****************************************
    // Active level per style; the reserved style never asserts
    logic active_w;
    always_comb begin
        case (cfg_r.style)
            STYLE_LEVEL: active_w = pending;
            STYLE_PERIODIC: active_w = pending && (cnt_r < PULSE_N);
            STYLE_ONESHOT: active_w = shot_r;
            default: active_w = 1'b0;
        endcase
    end
    // Registered pin keeps glitches off the board trace
    assign pin_nxt = cfg_r.irq_polarity ? active_w : !active_w;

    // ****************************************
    // State update
    // ****************************************
    // All state freezes while the clock enable is low
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cfg_r <= irq_cfg_t'(IRQ_CONFIG_RST);
            mask_r <= IRQ_SOURCE_MASKS_RST;
            latch_r <= IRQ_LATCHED_RST;
            cnt_r <= '0;
            shot_r <= 1'b0;
            rdata_r <= 8'h00;
            pin_r <= 1'b1;
        end else if (ce_in) begin
            cfg_r <= cfg_nxt;
            mask_r <= mask_nxt;
            latch_r <= latch_nxt;
            cnt_r <= cnt_nxt;
            shot_r <= shot_nxt;
            rdata_r <= rdata_nxt;
            pin_r <= pin_nxt;
        end
    end

    assign rdata_out = rdata_r;
    assign irq_pin_out = pin_r;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // Pin level follows polarity and the style's active term
    a_pin_polarity: assert property (
        $past(ce_in) && !$past(rst_in) |-> irq_pin_out ==
            ($past(cfg_r.irq_polarity) ? $past(active_w)
                                       : !$past(active_w)))
        else $error("pin polarity wrong");

    // Steady style tracks the pending term one cycle later
    a_level_follow: assert property (
        ce_in && cfg_r.style == STYLE_LEVEL |=>
            irq_pin_out == ($past(cfg_r.irq_polarity) ~^ $past(pending)))
        else $error("steady style not tracking pending");

    // Reserved style never drives the pin active
    a_reserved_quiet: assert property (
        ce_in && cfg_r.style == STYLE_RESERVED |=>
            irq_pin_out == !$past(cfg_r.irq_polarity))
        else $error("reserved style asserted pin");

    // Repeating style wraps its counter at the period end
    a_periodic_wrap: assert property (
        ce_in && cfg_r.style == STYLE_PERIODIC && pending &&
        cnt_r == PERIOD_LAST |=> cnt_r == '0)
        else $error("period counter did not wrap");

    // Repeating style shows the pin active in the first part of the period
    a_periodic_duty: assert property (
        ce_in && cfg_r.style == STYLE_PERIODIC && pending |=>
            irq_pin_out == ($past(cfg_r.irq_polarity)
                ~^ ($past(cnt_r) <= PULSE_LAST)))
        else $error("period duty wrong");

    // Single pulse starts on an unmasked event
    a_oneshot_start: assert property (
        ce_in && cfg_r.style == STYLE_ONESHOT && new_evt |=>
            shot_r && cnt_r == '0)
        else $error("single pulse did not start");

    // Single pulse ends after its last counted cycle
    a_oneshot_end: assert property (
        ce_in && cfg_r.style == STYLE_ONESHOT && shot_r && !new_evt &&
        cnt_r == PULSE_LAST |=> !shot_r)
        else $error("single pulse did not end");

    // Filtered readback hides masked sources
    a_readback_filter: assert property (
        ce_in && rd_latch_stb |=>
            rdata_out[7:6] == ($past(cfg_r.readback_filter_select)
                ? ($past(latch_r) & ~$past(mask_src)) : $past(latch_r))
            && rdata_out[5:0] == 6'h00)
        else $error("latch readback wrong");

    // Fully masked sources keep the steady pin idle
    a_masked_quiet: assert property (
        ce_in && mask_src == 2'b11 && cfg_r.style == STYLE_LEVEL |=>
            irq_pin_out == !$past(cfg_r.irq_polarity))
        else $error("masked source reached pin");

    // Register reset values
    a_reset_values: assert property (
        $past(rst_in) |-> mask_r == 8'hFF && cfg_r == '0 &&
            latch_r == '0)
        else $error("reset values wrong");

    // An event always lands in its latch, even during a read
    a_latch_set: assert property (
        ce_in && evt_w != '0 |=> (latch_r & $past(evt_w)) == $past(evt_w))
        else $error("event not latched");

    // A visible latch clears on its read when no new event arrives
    a_read_clear: assert property (
        ce_in && rd_latch_stb && evt_w == '0 |=>
            (latch_r & $past(latch_vis)) == '0)
        else $error("latch not cleared by read");

    // Latches hold their value until a read of the latch register
    a_latch_hold: assert property (
        ce_in && !rd_latch_stb && latch_r != '0 |=>
            (latch_r & $past(latch_r)) == $past(latch_r))
        else $error("latch lost without a read");

    // Every mask bit takes the written value, reserved bits included
    a_mask_write: assert property (
        ce_in && wr_mask |=> mask_r == $past(req_in.wdata))
        else $error("mask write lost");

    // Reserved configuration bits never hold a one
    a_cfg_reserved: assert property (
        cfg_r.rsv_hi == 2'h0 && cfg_r.rsv_lo == 2'h0)
        else $error("reserved config bit set");

    // Read data stands until the next taken read
    a_rdata_hold: assert property (
        ce_in && !req_in.rd |=> $stable(rdata_out))
        else $error("read data moved without a read");

    // A low clock enable freezes latches, registers and outputs
    a_ce_freeze: assert property (
        !ce_in |=> $stable(latch_r) && $stable(cfg_r) && $stable(mask_r)
            && $stable(irq_pin_out) && $stable(rdata_out))
        else $error("state moved with clock enable low");

    // Main scenarios
    c_level_assert: cover property (
        cfg_r.style == STYLE_LEVEL && pending ##1 rd_latch_stb);
    c_periodic_wrap: cover property (
        cfg_r.style == STYLE_PERIODIC && cnt_r == PERIOD_LAST);
    c_oneshot_done: cover property (
        shot_r && cnt_r == PULSE_LAST ##1 !shot_r);
    c_set_on_clear: cover property (
        ce_in && rd_latch_stb && (evt_w & latch_vis) != '0);
    // Filtered read while a masked latch stays hidden
    c_masked_hidden: cover property (
        cfg_r.readback_filter_select && rd_latch_stb &&
        (latch_r & mask_src) != '0);

endmodule

`default_nettype wire

/* File: verif/irq_host_model.sv */
// Host side model that watches the interrupt pin and tallies activity
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Pin watcher
// ****************************************
module irq_host_model (
    input wire logic clk_in,
    input wire logic clr_in,
    input wire logic pin_in,
    input wire logic pol_in,
    output logic [15:0] act_out,
    output logic [7:0] edg_out
);
    logic act;
    logic act_d;
    // The pin counts as active when its level equals the polarity setting
    assign act = ~(pin_in ^ pol_in);
    // Tally active cycles and the starts of active stretches
    always_ff @(posedge clk_in) begin
        act_d <= act;
        if (clr_in) begin
            act_out <= 16'h0000;
            edg_out <= 8'h00;
        end else begin
            act_out <= act_out + {15'h0000, act};
            edg_out <= edg_out + {7'h00, act & ~act_d};
        end
    end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the converter interrupt logic
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Bench top
// ****************************************
module tb_top;
    import irq_logic_pkg::*;
    // Short pulse figures keep the run small
    localparam int PUL = 4;
    localparam int PER = 8;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic clr = 1'b0;
    logic pol = 1'b0;
    reg_req_t req = '0;
    irq_evt_t evt = '0;
    logic [7:0] rdata;
    logic pin;
    logic [7:0] rv;
    logic [15:0] act;
    logic [7:0] edg;
    int bad_count = 0;
    int compares = 0;
    int cyc = 0;

    irq_logic #(.PULSE_CYC(PUL), .PERIOD_CYC(PER)) u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .req_in(req), .evt_in(evt),
        .rdata_out(rdata), .irq_pin_out(pin));
    irq_host_model u_host (
        .clk_in(clk_in), .clr_in(clr), .pin_in(pin), .pol_in(pol),
        .act_out(act), .edg_out(edg));

    // Clock at 100 ns
    initial begin
        forever #50 clk_in = ~clk_in;
    end

    task automatic results();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Every access starts and ends just after a falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_in);
        req = '0;
        @(negedge clk_in);
    endtask

    // Data is sampled a full cycle late; it holds until the next read
    task automatic rd(input logic [7:0] a);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_in);
        req = '0;
        @(negedge clk_in);
        rv = rdata;
        @(negedge clk_in);
    endtask

    // One-cycle event pulse; also ends any tally clear started by caller
    task automatic fire(input irq_evt_t e);
        evt = e;
        @(negedge clk_in);
        evt = '0;
        clr = 1'b0;
        repeat (3) @(negedge clk_in);
    endtask

    task automatic window(input int n);
        clr = 1'b1;
        @(negedge clk_in);
        clr = 1'b0;
        repeat (n) @(negedge clk_in);
    endtask

    initial begin
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        rd(ADDR_IRQ_CONFIG);
        chk("config reset", rv, 8'h00);
        rd(ADDR_IRQ_SOURCE_MASKS);
        chk("mask reset", rv, 8'hFF);
        rd(ADDR_IRQ_LATCHED_FLAGS);
        chk("latch reset", rv, 8'h00);
        chk("pin idle", pin, 1'b1);
        wr(ADDR_IRQ_SOURCE_MASKS, 8'hD5);
        ce_in = 1'b0;
        wr(ADDR_IRQ_SOURCE_MASKS, 8'h00);
        ce_in = 1'b1;
        rd(ADDR_IRQ_SOURCE_MASKS);
        chk("mask low bits", rv, 8'hD5);
        wr(ADDR_IRQ_CONFIG, 8'hFF);
        rd(ADDR_IRQ_CONFIG);
        chk("config bits", rv, 8'hE4);
        wr(ADDR_IRQ_SOURCE_MASKS, 8'hFF);
        wr(ADDR_IRQ_CONFIG, 8'h00);
        // Masked events still latch but leave the pin alone
        fire(2'b10);
        chk("masked pin", pin, 1'b1);
        rd(ADDR_IRQ_LATCHED_FLAGS);
        chk("latch clk err", rv, 8'h80);
        rd(ADDR_IRQ_LATCHED_FLAGS);
        chk("latch cleared", rv, 8'h00);
        // Filtered readback hides the masked lock event until unmasked
        wr(ADDR_IRQ_CONFIG, 8'h04);
        fire(2'b01);
        rd(ADDR_IRQ_LATCHED_FLAGS);
        chk("hidden latch", rv, 8'h00);
        wr(ADDR_IRQ_SOURCE_MASKS, 8'hBF);
        @(negedge clk_in);
        chk("lock pin", pin, 1'b0);
        rd(ADDR_IRQ_LATCHED_FLAGS);
        chk("latch lock", rv, 8'h40);
        chk("pin released", pin, 1'b1);
        wr(ADDR_IRQ_CONFIG, 8'h00);
        wr(ADDR_IRQ_SOURCE_MASKS, 8'h7F);
        fire(2'b10);
        chk("clk err pin", pin, 1'b0);
        rd(ADDR_IRQ_LATCHED_FLAGS);
        chk("latch clk err 2", rv, 8'h80);
        chk("level released", pin, 1'b1);
        // Active-high pin
        pol = 1'b1;
        wr(ADDR_IRQ_CONFIG, 8'h80);
        chk("high idle", pin, 1'b0);
        wr(ADDR_IRQ_SOURCE_MASKS, 8'h3F);
        fire(2'b01);
        chk("high active", pin, 1'b1);
        rd(ADDR_IRQ_LATCHED_FLAGS);
        chk("high released", pin, 1'b0);
        // Reserved style never asserts
        pol = 1'b0;
        wr(ADDR_IRQ_CONFIG, 8'h20);
        fire(2'b01);
        window(PER);
        chk("reserved style", act, 16'h0000);
        rd(ADDR_IRQ_LATCHED_FLAGS);
        // Periodic style: PUL active cycles in every PER while pending
        wr(ADDR_IRQ_CONFIG, 8'h40);
        fire(2'b01);
        window(3 * PER);
        chk("periodic count", act, 16'(3 * PUL));
        rd(ADDR_IRQ_LATCHED_FLAGS);
        window(PER);
        chk("periodic stop", act, 16'h0000);
        // One-shot style: a single pulse per unmasked event
        wr(ADDR_IRQ_CONFIG, 8'h60);
        clr = 1'b1;
        fire(2'b01);
        repeat (2 * PER) @(negedge clk_in);
        chk("shot length", act, 16'(PUL));
        chk("shot count", edg, 16'h0001);
        rd(ADDR_IRQ_LATCHED_FLAGS);
        wr(ADDR_IRQ_SOURCE_MASKS, 8'h7F);
        clr = 1'b1;
        fire(2'b01);
        repeat (2 * PER) @(negedge clk_in);
        chk("masked shot", act, 16'h0000);
        // Mid-run reset with a pending event returns all to reset values
        wr(ADDR_IRQ_CONFIG, 8'h04);
        fire(2'h2);
        chk("pre-reset pin", pin, 1'b0);
        rst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        rd(ADDR_IRQ_CONFIG);
        chk("config rerst", rv, 8'h00);
        rd(ADDR_IRQ_SOURCE_MASKS);
        chk("mask rerst", rv, 8'hFF);
        rd(ADDR_IRQ_LATCHED_FLAGS);
        chk("latch rerst", rv, 8'h00);
        chk("pin rerst", pin, 1'b1);
        results();
    end
endmodule
`default_nettype wire
